// File: cip_top.sv
`timescale 1ns/1ps
`include "cip_defs.svh"

module cip_top
    import cip_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        timer_out0,
    input  wire logic        kbd_obf,
    input  wire logic [15:0] irq_in,
    input  wire logic        parity_err,
    input  wire logic        nmi_gate_wr,
    input  wire logic        nmi_gate_val,
    input  wire logic        int_ack,
    output cip_grant_t       grant
);

    // Three-stage synchronisers for the timer, keyboard, parity and irq_in[15:3] pin inputs
    logic [17:0] s1;
    logic [17:0] s2;
    logic [17:0] s3;
    logic [17:0] pin_now;
    logic [17:0] stable;

    always_comb begin
        // Bit 0 parity, 15:3 request lines, 16 timer, 17 keyboard
        pin_now = {kbd_obf, timer_out0, irq_in[15:3], 2'b00, parity_err};
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1 <= 18'h0;
            s2 <= 18'h0;
            s3 <= 18'h0;
        end else begin
            s1 <= pin_now;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change counts only when the last two stages agree
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stable <= 18'h0;
        end else begin
            stable <= (s2 & s3) | (stable & (s2 | s3));
        end
    end

    logic        nmi_block;
    logic [15:0] req;
    logic        slave_any;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nmi_block <= `CIP_NMI_GATE_RST;
        end else if (nmi_gate_wr) begin
            nmi_block <= nmi_gate_val;
        end
    end

    always_comb begin
        req = {stable[15:3], 3'b000};
        req[`CIP_LINE_TIMER] = stable[16];
        req[`CIP_LINE_KBD]   = stable[17];
        req = req & ~`CIP_RSVD_MASK;
        slave_any = |req[15:8];
        req[`CIP_LINE_CASCADE] = slave_any;
    end

    // Priority pick over all pending lines in fixed order
    logic        any;
    logic [3:0]  pick;
    always_comb begin
        any  = 1'b1;
        pick = 4'h0;
        if (req[0]) begin
            pick = 4'h0;
        end else if (req[1]) begin
            pick = 4'h1;
        end else if (req[`CIP_LINE_CASCADE]) begin
            pick = 4'h8;
            for (int i = 15; i >= 8; i--) begin
                if (req[i]) begin
                    pick = 4'(i);
                end
            end
        end else begin
            any  = 1'b0;
            for (int i = 7; i >= 3; i--) begin
                if (req[i]) begin
                    pick = 4'(i);
                    any  = 1'b1;
                end
            end
        end
    end

    // One request at a time: hold the grant until acknowledged
    cip_state_t state;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state      <= CIP_IDLE;
            grant.intr <= 1'b0;
            grant.line <= 4'h0;
        end else begin
            case (state)
                CIP_IDLE: begin
                    if (any) begin
                        grant.intr <= 1'b1;
                        grant.line <= pick;
                        state      <= CIP_BUSY;
                    end
                end
                CIP_BUSY: begin
                    if (int_ack) begin
                        grant.intr <= 1'b0;
                        state      <= CIP_DONE;
                    end
                end
                default: begin
                    state <= CIP_IDLE;
                end
            endcase
        end
    end

    property p_one_at_time;
        @(posedge ref_clk) disable iff (sys_rst)
        grant.intr && !int_ack |=> grant.intr && $stable(grant.line);
    endproperty
    a_one_at_time: assert property (p_one_at_time)
        else $error("Grant changed before ack");

    property p_ack_ends;
        @(posedge ref_clk) disable iff (sys_rst)
        state == CIP_BUSY && int_ack |=> !grant.intr;
    endproperty
    a_ack_ends: assert property (p_ack_ends)
        else $error("Grant held after ack");

    property p_timer_first;
        @(posedge ref_clk) disable iff (sys_rst)
        state == CIP_IDLE && req[0] |=> grant.line == 4'h0;
    endproperty
    a_timer_first: assert property (p_timer_first)
        else $error("Timer line not granted first");

    property p_kbd_second;
        @(posedge ref_clk) disable iff (sys_rst)
        state == CIP_IDLE && !req[0] && req[1] |=> grant.line == 4'h1;
    endproperty
    a_kbd_second: assert property (p_kbd_second)
        else $error("Keyboard line order wrong");

    property p_slave_over_master;
        @(posedge ref_clk) disable iff (sys_rst)
        state == CIP_IDLE && !req[0] && !req[1] && slave_any
        |=> grant.line >= 4'h8;
    endproperty
    a_slave_over_master: assert property (p_slave_over_master)
        else $error("Slave lost to low master");

    property p_master_low;
        @(posedge ref_clk) disable iff (sys_rst)
        state == CIP_IDLE && any && !req[0] && !req[1] && !slave_any
        |=> grant.line >= 4'h3 && grant.line <= 4'h7;
    endproperty
    a_master_low: assert property (p_master_low)
        else $error("Low master line out of range");

    property p_no_drop;
        @(posedge ref_clk) disable iff (sys_rst)
        state == CIP_IDLE && any |=> grant.intr;
    endproperty
    a_no_drop: assert property (p_no_drop)
        else $error("Pending request dropped");

    property p_order;
        @(posedge ref_clk) disable iff (sys_rst)
        state == CIP_IDLE && req[3] && req[9] && !req[0] && !req[1] &&
        !req[8] |=> grant.line == 4'h9;
    endproperty
    a_order: assert property (p_order)
        else $error("Priority order wrong");

    property p_rsvd;
        @(posedge ref_clk) disable iff (sys_rst)
        grant.intr |-> grant.line != 4'ha && grant.line != 4'hb &&
        grant.line != 4'hf;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("Reserved line granted");

    // Parity error NMI, gated; highest rank, independent of grant
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            grant.nmi <= 1'b0;
        end else begin
            grant.nmi <= stable[0] & ~nmi_block;
        end
    end

    property p_nmi_gate;
        @(posedge ref_clk) disable iff (sys_rst)
        nmi_block |=> !grant.nmi;
    endproperty
    a_nmi_gate: assert property (p_nmi_gate)
        else $error("NMI passed closed gate");

    property p_nmi_pass;
        @(posedge ref_clk) disable iff (sys_rst)
        !nmi_block && stable[0] |=> grant.nmi;
    endproperty
    a_nmi_pass: assert property (p_nmi_pass)
        else $error("NMI not raised through open gate");

endmodule

// File: cip_defs.svh
`ifndef CIP_DEFS_SVH
`define CIP_DEFS_SVH

// Line numbers of the timer, keyboard and cascade request lines
`define CIP_LINE_TIMER     4'h0
`define CIP_LINE_KBD       4'h1
`define CIP_LINE_CASCADE   4'h2
// Position of the NMI gate in the control port at 70H
`define CIP_NMI_GATE_BIT   7
// Request lines that are tied inactive
`define CIP_RSVD_MASK      16'h8c00
// Gate value after reset: NMI blocked until software opens it
`define CIP_NMI_GATE_RST   1'b1

`endif

// File: cip_pkg.sv
package cip_pkg;

    typedef struct packed {
        logic       nmi;
        logic       intr;
        logic [3:0] line;
    } cip_grant_t;

    typedef enum logic [2:0] {
        CIP_IDLE = 3'b001,
        CIP_BUSY = 3'b010,
        CIP_DONE = 3'b100
    } cip_state_t;

endpackage

// File: cip_cpu_model.sv
`timescale 1ns/1ps
// Processor core: acknowledges each grant after ack_wait cycles
module cip_cpu_model
    import cip_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  cip_grant_t      grant,
    input  wire logic [3:0] ack_wait,
    output logic            int_ack
);
    logic [3:0] cnt;
    // A slow core keeps the grant held, so late requests must queue
    always @(negedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 4'h0;
            int_ack <= 1'b0;
        end else if (int_ack || !grant.intr) begin
            cnt <= 4'h0;
            int_ack <= 1'b0;
        end else if (cnt == ack_wait) begin
            int_ack <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// File: cascaded_interrupt_priority_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    err_total++; $display("MISMATCH %0t %h %h", $time, a, e); end end
module cascaded_interrupt_priority_tb;
    import cip_pkg::*;
    logic        ref_clk, sys_rst, timer_out0, kbd_obf, parity_err;
    logic        nmi_gate_wr, nmi_gate_val, int_ack;
    logic [15:0] irq_in;
    logic [3:0]  ack_wait;
    cip_grant_t  grant;
    int          err_total, samples_checked;
    logic [3:0]  ord [12] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hc, 4'hd,
                              4'he, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    cip_top i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .timer_out0(timer_out0), .kbd_obf(kbd_obf), .irq_in(irq_in),
        .parity_err(parity_err), .nmi_gate_wr(nmi_gate_wr),
        .nmi_gate_val(nmi_gate_val), .int_ack(int_ack), .grant(grant));
    cip_cpu_model i_cpu (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .grant(grant), .ack_wait(ack_wait), .int_ack(int_ack));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic idle(input int c);
        repeat (c) @(negedge ref_clk);
    endtask
    task automatic wrap_up;
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Waits for a grant, checks its line and withdraws that source
    task automatic serve(input logic [3:0] exp);
        int n;
        n = 0;
        while (grant.intr !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(grant.intr, 1'b1)
        `CHK(grant.line, exp)
        if (exp == 4'h0) timer_out0 = 1'b0;
        else if (exp == 4'h1) kbd_obf = 1'b0;
        else irq_in[exp] = 1'b0;
        n = 0;
        while (grant.intr !== 1'b0 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic t_nmi;
        parity_err = 1'b1;
        idle(8);
        `CHK(grant.nmi, 1'b0)
        nmi_gate_val = 1'b0;
        nmi_gate_wr = 1'b1;
        idle(1);
        nmi_gate_wr = 1'b0;
        idle(8);
        `CHK(grant.nmi, 1'b1)
        `CHK(grant.intr, 1'b0)
        parity_err = 1'b0;
        idle(8);
        `CHK(grant.nmi, 1'b0)
        parity_err = 1'b1;
        idle(8);
        `CHK(grant.nmi, 1'b1)
        nmi_gate_val = 1'b1;
        nmi_gate_wr = 1'b1;
        idle(1);
        nmi_gate_wr = 1'b0;
        idle(2);
        `CHK(grant.nmi, 1'b0)
        parity_err = 1'b0;
    endtask
    task automatic t_single;
        ack_wait = 4'hc;
        timer_out0 = 1'b1;
        serve(4'h0);
        kbd_obf = 1'b1;
        serve(4'h1);
        irq_in[9] = 1'b1;
        serve(4'h9);
    endtask
    // Reserved slave lines and the three master-side bits stay silent
    task automatic t_rsvd;
        irq_in = 16'h8c07;
        idle(20);
        `CHK(grant.intr, 1'b0)
        irq_in = 16'h0000;
    endtask
    task automatic t_order;
        ack_wait = 4'h8;
        timer_out0 = 1'b1;
        kbd_obf = 1'b1;
        irq_in = 16'hffff;
        for (int i = 0; i < 12; i++) begin
            serve(ord[i]);
        end
        idle(20);
        `CHK(grant.intr, 1'b0)
        irq_in = 16'h0000;
    endtask
    // Reset in mid-run drops the grant and closes the NMI gate again
    task automatic t_reset;
        nmi_gate_val = 1'b0;
        nmi_gate_wr = 1'b1;
        idle(1);
        nmi_gate_wr = 1'b0;
        timer_out0 = 1'b1;
        parity_err = 1'b1;
        idle(8);
        `CHK(grant.nmi, 1'b1)
        `CHK(grant.intr, 1'b1)
        sys_rst = 1'b1;
        idle(2);
        `CHK(grant, 6'h00)
        sys_rst = 1'b0;
        idle(8);
        `CHK(grant.nmi, 1'b0)
        parity_err = 1'b0;
        serve(4'h0);
    endtask
    initial begin
        sys_rst = 1'b1;
        {timer_out0, kbd_obf, parity_err, nmi_gate_wr} = 4'h0;
        nmi_gate_val = 1'b1;
        irq_in = 16'h0000;
        ack_wait = 4'h8;
        err_total = 0;
        samples_checked = 0;
        idle(16);
        sys_rst = 1'b0;
        idle(2);
        t_nmi;
        t_single;
        t_rsvd;
        t_order;
        t_reset;
        wrap_up;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        wrap_up;
    end
endmodule
